// ---- core/hbrs_map.svh ----
`ifndef HBRS_MAP_SVH
`define HBRS_MAP_SVH

// Post-release hold of the processor reset, in processor bus clocks
`define HBRS_HOLD_LOG2      17
`define HBRS_HOLD_CYCLES    32'h0002_0000

// Minimum hard reset pulse the outside must give
`define HBRS_MIN_PULSE_US   100
`define HBRS_MIN_PULSE_PCI  255
`define HBRS_PCI_RESET_MS   1

// Synchroniser depth
`define HBRS_SYNC_STAGES    2

`endif

// ---- core/hbrs_pkg.sv ----
package hbrs_pkg;

    typedef enum logic [2:0] {
        HBRS_ST_HOLD    = 3'b001,
        HBRS_ST_COUNT   = 3'b010,
        HBRS_ST_RUN     = 3'b100
    } hbrs_state_t;

endpackage : hbrs_pkg

// ---- core/hbrs_sequencer.sv ----
// How it works
// R1 - Outside must hold hard reset at least 100 us plus 255 PCI clocks.
// R2 - PCI bus reset, held 1 ms or more, may drive hard reset.
// R3 - Processor reset output is asserted whenever PCI bus reset is asserted.
// R4 - After hard reset releases, hold processor reset 2^17 more bus clocks.
// R5 - Processor reset is open-drain: drive low when asserted, float otherwise.
// R6 - Software can assert soft reset output to restart the processor.
// R7 - Hard reset asserted clears the soft reset output.
// R8 - Outside controller should debounce soft reset before driving hard reset.
// R9 - Delay counter on bus clock, cleared during hard reset, releases synchronously.
`timescale 1ns/10ps
`default_nettype none
`include "hbrs_map.svh"

module hbrs_sequencer #(
    parameter int HOLD_CYCLES = `HBRS_HOLD_CYCLES
) (
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  rst,
    // Reset pins, active low, asynchronous to clk_sys
    input  wire logic  hard_reset_in_n,
    input  wire logic  pci_reset_n,
    // Processor reset, open-drain
    output var  logic  cpu_reset_out_o,
    output var  logic  cpu_reset_out_oe_n,
    // Soft reset control from interrupt controller logic
    input  wire logic  soft_reset_req,
    input  wire logic  soft_reset_rel,
    output var  logic  soft_reset_out_n,
    // Status
    output var  logic  cpu_reset_active,
    output var  hbrs_pkg::hbrs_state_t state
);
    import hbrs_pkg::*;

    // ------------------------------------------------------------
    // Constants and declarations
    // ------------------------------------------------------------
    localparam int            CW       = `HBRS_HOLD_LOG2 + 1;
    localparam int            NPIN     = 2;
    localparam int            PIN_HARD = 0;
    localparam int            PIN_PCI  = 1;
    localparam logic [CW-1:0] CNT_LAST = CW'(HOLD_CYCLES - 1);

    logic [NPIN-1:0] pin_raw_n;
    logic [NPIN-1:0] pin_sync_n;
    logic            hard_act;
    logic [CW-1:0]   cnt_q;
    logic [CW-1:0]   cnt_d;
    hbrs_state_t     state_d;
    logic            soft_d;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Processor reset is released only in the run state
    function automatic logic st_is_run(input hbrs_state_t s);
        return (s == HBRS_ST_RUN);
    endfunction : st_is_run

    // Any synchronised pin low holds the sequence
    function automatic logic any_low(input logic [NPIN-1:0] p);
        return (p != {NPIN{1'b1}});
    endfunction : any_low

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pin_raw_n[PIN_HARD] = hard_reset_in_n;
    assign pin_raw_n[PIN_PCI]  = pci_reset_n;

    // Both pins are asynchronous; reset to asserted
    for (genvar g = 0; g < NPIN; g++) begin : g_pin_sync
        hbrs_sync #(
            .RESET_VAL (1'b0)
        ) u_sync (
            .clk_sys (clk_sys),
            .rst     (rst),
            .din     (pin_raw_n[g]),
            .dout    (pin_sync_n[g])
        );
    end

    // ------------------------------------------------------------
    // Reset source decode
    // ------------------------------------------------------------
    assign hard_act = any_low(pin_sync_n); // R3 R7

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state;
        case (state)
            HBRS_ST_HOLD: begin
                if (!hard_act) begin
                    state_d = HBRS_ST_COUNT;
                end
            end
            HBRS_ST_COUNT: begin
                if (hard_act) begin
                    state_d = HBRS_ST_HOLD; // R9
                end else if (cnt_q == CNT_LAST) begin
                    state_d = HBRS_ST_RUN; // R4
                end
            end
            HBRS_ST_RUN: begin
                if (hard_act) begin
                    state_d = HBRS_ST_HOLD; // R3
                end
            end
            default: begin
                state_d = HBRS_ST_HOLD;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Counter next value
    // ------------------------------------------------------------
    // Restart from zero whenever a pin drops
    always_comb begin
        cnt_d = '0;
        case (state)
            HBRS_ST_COUNT: begin
                if (!hard_act) begin
                    cnt_d = cnt_q + CW'(1); // R9
                end
            end
            default: begin
                cnt_d = '0; // R9
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= HBRS_ST_HOLD;
        end else begin
            state <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Counter register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Processor reset pin data
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cpu_reset_out_o <= 1'b0;
        end else begin
            cpu_reset_out_o <= 1'b0; // R5
        end
    end

    // ------------------------------------------------------------
    // Processor reset pin enable
    // ------------------------------------------------------------
    // Low enable pulls the wired line low
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cpu_reset_out_oe_n <= 1'b0;
        end else begin
            cpu_reset_out_oe_n <= st_is_run(state_d); // R5 R9
        end
    end

    // ------------------------------------------------------------
    // Processor reset status
    // ------------------------------------------------------------
    // Mirrors the pin enable in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cpu_reset_active <= 1'b1;
        end else begin
            cpu_reset_active <= !st_is_run(state_d); // R4
        end
    end

    // ------------------------------------------------------------
    // Soft reset next value
    // ------------------------------------------------------------
    // Clear by hard reset beats a set request
    always_comb begin
        soft_d = soft_reset_out_n;
        if (hard_act) begin
            soft_d = 1'b1; // R7
        end else if (soft_reset_req) begin
            soft_d = 1'b0; // R6
        end else if (soft_reset_rel) begin
            soft_d = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Soft reset register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            soft_reset_out_n <= 1'b1;
        end else begin
            soft_reset_out_n <= soft_d; // R6 R7
        end
    end

endmodule : hbrs_sequencer

`default_nettype wire

// ---- core/hbrs_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Two-stage level synchroniser, set to a constant under reset
// ----------------------------------------------------------------
module hbrs_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Level
    input  wire logic din,
    output var  logic dout
);

    logic meta_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            dout   <= RESET_VAL;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule : hbrs_sync

`default_nettype wire

// ---- verification/hbrs_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module hbrs_host_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cpu_reset_out_o,
    input wire logic cpu_reset_out_oe_n,
    input wire logic soft_reset_out_n,
    output var logic cpu_rst_line_n,
    output var logic sys_reset_n
);
    logic [3:0] cnt_q;
    // Pull-up on the wired reset line
    assign cpu_rst_line_n = cpu_reset_out_oe_n ? 1'b1 : cpu_reset_out_o;
    // Debounce stretch of soft reset into hard reset
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            cnt_q <= '0;
        else if (!soft_reset_out_n)
            cnt_q <= 4'h8;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    assign sys_reset_n = soft_reset_out_n && cnt_q == 4'h0;
endmodule : hbrs_host_model
`default_nettype wire

// ---- verification/hbrs_seq_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module hbrs_seq_monitor #(parameter int HOLD_CYCLES = 16) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Pins and controls
    input wire logic hard_reset_in_n,
    input wire logic pci_reset_n,
    input wire logic soft_reset_req,
    // Outputs
    input wire logic cpu_reset_out_o,
    input wire logic cpu_reset_out_oe_n,
    input wire logic soft_reset_out_n,
    input wire logic cpu_reset_active,
    input wire hbrs_pkg::hbrs_state_t state
);
    import hbrs_pkg::*;
    logic [31:0] up_q;
    // Cycles with both pins high
    always_ff @(posedge clk_sys or posedge rst)
        if (rst || !(hard_reset_in_n && pci_reset_n))
            up_q <= '0;
        else
            up_q <= up_q + 1;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_PCI_HOLDS:
    assert property (!pci_reset_n [*4] |-> !cpu_reset_out_oe_n) else $error("cpu reset free");
    AST_HOLD_LEN:
    assert property ($rose(cpu_reset_out_oe_n) |-> up_q >= HOLD_CYCLES + 1
        && up_q <= HOLD_CYCLES + 4) else $error("hold length wrong");
    AST_OPEN_DRAIN:
    assert property (!cpu_reset_out_o && cpu_reset_active == !cpu_reset_out_oe_n)
        else $error("open drain wrong");
    AST_SOFT_SET:
    assert property ((hard_reset_in_n && pci_reset_n) [*4] ##0 soft_reset_req
        |=> !soft_reset_out_n) else $error("soft reset not set");
    AST_SOFT_CLEAR:
    assert property (!hard_reset_in_n [*4] |-> soft_reset_out_n) else $error("soft not cleared");
    AST_COUNT_RESTART:
    assert property (state == HBRS_ST_COUNT && !hard_reset_in_n |-> ##[1:4]
        state == HBRS_ST_HOLD) else $error("count not restarted");
endmodule : hbrs_seq_monitor
bind hbrs_sequencer hbrs_seq_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (.clk_sys, .rst,
    .hard_reset_in_n, .pci_reset_n, .soft_reset_req, .cpu_reset_out_o, .cpu_reset_out_oe_n,
    .soft_reset_out_n, .cpu_reset_active, .state);
`default_nettype wire

// ---- verification/host_bridge_reset_sequencer_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_bridge_reset_sequencer_test;
    import hbrs_pkg::*;
    localparam int HOLD = 16;
    logic clk_sys = 1'b0, rst = 1'b1, hard_n = 1'b1, pci_reset_n = 1'b1, loop_en = 1'b0;
    logic soft_reset_req = 1'b0, soft_reset_rel = 1'b0, line_n, sys_n;
    logic cpu_reset_out_o, cpu_reset_out_oe_n, soft_reset_out_n, cpu_reset_active;
    hbrs_state_t state;
    int bad_count = 0, checked = 0, n;
    // Rows: hard, pci, req, rel, oe_n, soft_n
    logic [5:0] rows [9] = '{6'h33, 6'h3A, 6'h37, 6'h3E, 6'h11, 6'h3A, 6'h21, 6'h29, 6'h33};
    always #10 clk_sys = ~clk_sys;
    hbrs_sequencer #(.HOLD_CYCLES(HOLD)) u_dut (.clk_sys, .rst, .pci_reset_n,
        .hard_reset_in_n(hard_n & (sys_n | !loop_en)), .cpu_reset_out_o, .cpu_reset_out_oe_n,
        .soft_reset_req, .soft_reset_rel, .soft_reset_out_n, .cpu_reset_active, .state);
    hbrs_host_model u_host (.clk_sys, .rst, .cpu_reset_out_o, .cpu_reset_out_oe_n,
        .soft_reset_out_n, .cpu_rst_line_n(line_n), .sys_reset_n(sys_n));
    task chk(input logic [2:0] seen, input logic [2:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %b exp %b", $time, seen, exp);
        end
    endtask : chk
    task tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick
    task end_sim;
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    initial begin
        #20000;
        bad_count++;
        end_sim;
    end
    initial begin
        tick(16);
        chk({cpu_reset_out_oe_n, soft_reset_out_n, cpu_reset_active}, 3'h3);
        chk(state, HBRS_ST_HOLD);
        $display("reset done");
        rst = 1'b0;
        for (int i = 0; i < 9; i++) begin
            {hard_n, pci_reset_n, soft_reset_req, soft_reset_rel} = rows[i][5:2];
            tick(24);
            chk({cpu_reset_out_oe_n, soft_reset_out_n}, rows[i][1:0]);
            chk(line_n, rows[i][1]);
            chk(cpu_reset_active, !rows[i][1]);
        end
        $display("table done");
        hard_n = 1'b0;
        tick(4);
        hard_n = 1'b1;
        tick(8);
        hard_n = 1'b0;
        tick(2);
        hard_n = 1'b1;
        n = 0;
        while (cpu_reset_out_oe_n !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk(n >= HOLD + 2 && n <= HOLD + 4, 1'b1);
        chk(state, HBRS_ST_RUN);
        $display("hold done");
        loop_en = 1'b1;
        soft_reset_req = 1'b1;
        tick(1);
        soft_reset_req = 1'b0;
        tick(6);
        chk({cpu_reset_out_oe_n, soft_reset_out_n}, 2'h1);
        tick(40);
        chk({cpu_reset_out_oe_n, soft_reset_out_n}, 2'h3);
        $display("loop done");
        end_sim;
    end
endmodule : host_bridge_reset_sequencer_test
`default_nettype wire
